/* File: dis_host_model.sv */
// host model: reads the information status word in one access
`timescale 1ns/100ps
module dis_host_model
   import dis_pkg::*;
(
   // clock
   input wire logic core_clk_i,
   // status seen at the link
   input wire logic [STATUS_W-1:0] status_i,
   // last word read
   output logic [STATUS_W-1:0] read_word_o
);
   // whole word taken at one edge so no field tears across reads
   always_ff @(posedge core_clk_i) begin
      read_word_o <= status_i;
   end
endmodule : dis_host_model

/* File: dis_limit_flag.sv */
// sticky threshold flag that clears only after the threshold is rewritten
`timescale 1ns/100ps
module dis_limit_flag
   import dis_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // comparison inputs
   input wire logic [CNT_W-1:0] value_i,
   input wire logic [CNT_W-1:0] threshold_i,
   input wire logic threshold_wr_i,
   // flag
   output logic flag_o
);
   logic rewritten;
   logic reached;

   assign reached = value_i >= threshold_i;

   // remembers that software touched the threshold since the flag rose
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rewritten <= 1'b0;
      end else if (!flag_o || reached) begin
         rewritten <= threshold_wr_i ? 1'b1 : (flag_o & rewritten);
      end else if (threshold_wr_i) begin
         rewritten <= 1'b1;
      end
   end

   // set wins; clear needs a rewrite plus the value back under threshold
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         flag_o <= 1'b0;
      end else if (reached) begin
         flag_o <= 1'b1;
      end else if (rewritten || threshold_wr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule : dis_limit_flag

/* File: dis_pkg.sv */
// package: status word layout and timing constants
package dis_pkg;
   localparam int unsigned STATUS_W = 32;
   localparam int unsigned VAL_W = 16;
   localparam int unsigned CNT_W = 32;
   // bit positions of the information items
   localparam int unsigned BIT_DRV_TEMP = 2;
   localparam int unsigned BIT_OVERVOLT = 4;
   localparam int unsigned BIT_UNDERVOLT = 5;
   localparam int unsigned BIT_LOAD = 7;
   localparam int unsigned BIT_SPEED = 8;
   localparam int unsigned BIT_OPDATA_ERR = 9;
   localparam int unsigned BIT_OP_PROHIB = 12;
   localparam int unsigned BIT_SERIAL_ERR = 15;
   localparam int unsigned BIT_ROT_METER = 19;
   localparam int unsigned BIT_TRIPMETER = 20;
   localparam int unsigned BIT_ODOMETER = 21;
   localparam int unsigned BIT_TRQ_ERR = 24;
   localparam int unsigned BIT_SPD_ERR = 25;
   localparam int unsigned BIT_PTIME = 26;
   localparam int unsigned BIT_PCOUNT = 27;
   localparam int unsigned BIT_START_LIM = 28;
   localparam int unsigned BIT_IO_TEST = 29;
   localparam int unsigned BIT_CFG_REQ = 30;
   localparam int unsigned BIT_PWR_CYC = 31;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 32'h0000_0000;
   // bits with an assigned item; every other bit reads zero
   localparam logic [STATUS_W-1:0] STATUS_USED_MASK = 32'hff38_93b4;
   // nonvolatile save interval
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SAVE_INTERVAL_S = 60;
   localparam longint unsigned SAVE_CYCLES =
      longint'(CLK_HZ) * longint'(SAVE_INTERVAL_S);
endpackage : dis_pkg

/* File: dis_status_word.sv */
// information status word for the motor driver
`timescale 1ns/100ps
module dis_status_word
   import dis_pkg::*;
#(
   parameter longint unsigned SAVE_PERIOD = SAVE_CYCLES
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // setting values and their limits
   input wire logic [VAL_W-1:0] torque_limit_i,
   input wire logic [VAL_W-1:0] torque_limit_max_i,
   input wire logic [VAL_W-1:0] speed_set_i,
   input wire logic [VAL_W-1:0] speed_upper_i,
   input wire logic [VAL_W-1:0] speed_lower_i,
   // power time and count thresholds
   input wire logic [CNT_W-1:0] power_time_i,
   input wire logic [CNT_W-1:0] power_time_thr_i,
   input wire logic power_time_thr_wr_i,
   input wire logic [CNT_W-1:0] power_count_i,
   input wire logic [CNT_W-1:0] power_count_thr_i,
   input wire logic power_count_thr_wr_i,
   // activity levels and change events
   input wire logic teach_busy_i,
   input wire logic config_busy_i,
   input wire logic data_write_busy_i,
   input wire logic restore_busy_i,
   input wire logic io_test_busy_i,
   input wire logic config_param_chg_i,
   input wire logic config_exec_i,
   input wire logic reboot_param_chg_i,
   // serial error counting
   input wire logic [VAL_W-1:0] comm_err_count_i,
   input wire logic [VAL_W-1:0] comm_err_thr_i,
   input wire logic comm_err_i,
   input wire logic comm_ok_i,
   // conditions of the lower items, computed elsewhere
   input wire logic drv_temp_cond_i,
   input wire logic overvolt_cond_i,
   input wire logic undervolt_cond_i,
   input wire logic load_cond_i,
   input wire logic speed_cond_i,
   input wire logic opdata_err_cond_i,
   input wire logic op_prohib_cond_i,
   input wire logic rot_meter_cond_i,
   input wire logic tripmeter_cond_i,
   input wire logic odometer_cond_i,
   // status and save strobe
   output logic [STATUS_W-1:0] information_status_word_o,
   output logic nv_save_o
);
   logic torque_limit_setting_error_flag;
   logic speed_setting_error_flag;
   logic power_on_time_flag;
   logic power_on_count_flag;
   logic start_limit_mode_flag;
   logic io_test_mode_flag;
   logic configuration_request_flag;
   logic power_cycle_request_flag;
   logic serial_comm_error_flag;
   logic [STATUS_W-1:0] next_status;
   logic [31:0] save_cnt;

   // recomputed from the live conditions every cycle
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         torque_limit_setting_error_flag <= 1'b0;
      end else begin
         torque_limit_setting_error_flag <=
            torque_limit_i > torque_limit_max_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         speed_setting_error_flag <= 1'b0;
      end else begin
         speed_setting_error_flag <= (speed_set_i > speed_upper_i) ||
            (speed_set_i < speed_lower_i);
      end
   end

   dis_limit_flag u_ptime (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .value_i(power_time_i),
      .threshold_i(power_time_thr_i),
      .threshold_wr_i(power_time_thr_wr_i),
      .flag_o(power_on_time_flag)
   );

   dis_limit_flag u_pcount (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .value_i(power_count_i),
      .threshold_i(power_count_thr_i),
      .threshold_wr_i(power_count_thr_wr_i),
      .flag_o(power_on_count_flag)
   );

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         start_limit_mode_flag <= 1'b0;
         io_test_mode_flag <= 1'b0;
      end else begin
         start_limit_mode_flag <= teach_busy_i | config_busy_i |
            data_write_busy_i | restore_busy_i;
         io_test_mode_flag <= io_test_busy_i | config_busy_i;
      end
   end

   // a change in the same cycle as the configuration wins
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         configuration_request_flag <= 1'b0;
      end else if (config_param_chg_i) begin
         configuration_request_flag <= 1'b1;
      end else if (config_exec_i) begin
         configuration_request_flag <= 1'b0;
      end
   end

   // only the power-on reset clears this one
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         power_cycle_request_flag <= 1'b0;
      end else if (reboot_param_chg_i) begin
         power_cycle_request_flag <= 1'b1;
      end
   end

   // an error with the count at or over the threshold beats a good frame in the same cycle
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         serial_comm_error_flag <= 1'b0;
      end else if (comm_err_i && comm_err_count_i >= comm_err_thr_i) begin
         serial_comm_error_flag <= 1'b1;
      end else if (comm_ok_i) begin
         serial_comm_error_flag <= 1'b0;
      end
   end

   always_comb begin
      next_status = STATUS_RESET;
      next_status[BIT_DRV_TEMP] = drv_temp_cond_i;
      next_status[BIT_OVERVOLT] = overvolt_cond_i;
      next_status[BIT_UNDERVOLT] = undervolt_cond_i;
      next_status[BIT_LOAD] = load_cond_i;
      next_status[BIT_SPEED] = speed_cond_i;
      next_status[BIT_OPDATA_ERR] = opdata_err_cond_i;
      next_status[BIT_OP_PROHIB] = op_prohib_cond_i;
      next_status[BIT_SERIAL_ERR] = serial_comm_error_flag;
      next_status[BIT_ROT_METER] = rot_meter_cond_i;
      next_status[BIT_TRIPMETER] = tripmeter_cond_i;
      next_status[BIT_ODOMETER] = odometer_cond_i;
      next_status[BIT_TRQ_ERR] = torque_limit_setting_error_flag;
      next_status[BIT_SPD_ERR] = speed_setting_error_flag;
      next_status[BIT_PTIME] = power_on_time_flag;
      next_status[BIT_PCOUNT] = power_on_count_flag;
      next_status[BIT_START_LIM] = start_limit_mode_flag;
      next_status[BIT_IO_TEST] = io_test_mode_flag;
      next_status[BIT_CFG_REQ] = configuration_request_flag;
      next_status[BIT_PWR_CYC] = power_cycle_request_flag;
   end

   // whole word registered at once so one read sees a coherent code
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         information_status_word_o <= STATUS_RESET;
      end else begin
         information_status_word_o <=
            next_status & STATUS_USED_MASK;
      end
   end

   // up to a minute of rotation is lost if power drops between saves
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         save_cnt <= '0;
         nv_save_o <= 1'b0;
      end else if (save_cnt == 32'(SAVE_PERIOD - 1)) begin
         save_cnt <= '0;
         nv_save_o <= 1'b1;
      end else begin
         save_cnt <= save_cnt + 32'h0000_0001;
         nv_save_o <= 1'b0;
      end
   end

   // checks
   AST_TRQ: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (torque_limit_i > torque_limit_max_i) |->
      ##2 information_status_word_o[BIT_TRQ_ERR])
      else $error("torque error bit not set");
   AST_TRQ_CLR: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (torque_limit_i <= torque_limit_max_i) |->
      ##2 !information_status_word_o[BIT_TRQ_ERR])
      else $error("torque error bit set while limit is legal");
   AST_SPD: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (speed_set_i >= speed_lower_i && speed_set_i <= speed_upper_i)
      |-> ##2 !information_status_word_o[BIT_SPD_ERR])
      else $error("speed error bit set while in range");
   AST_SPD_SET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (speed_set_i > speed_upper_i || speed_set_i < speed_lower_i)
      |-> ##2 information_status_word_o[BIT_SPD_ERR])
      else $error("speed error bit missing");
   AST_PTIME: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (power_time_i >= power_time_thr_i) |-> ##1 power_on_time_flag)
      else $error("power time flag missing");
   AST_PTIME_RISE: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !power_on_time_flag && power_time_i < power_time_thr_i
      |=> !power_on_time_flag)
      else $error("power time flag rose below threshold");
   AST_PCOUNT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (power_on_count_flag && !power_count_thr_wr_i
       && power_count_i >= power_count_thr_i) |=>
      power_on_count_flag)
      else $error("power count flag dropped early");
   AST_PCOUNT_RISE: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !power_on_count_flag && power_count_i < power_count_thr_i
      |=> !power_on_count_flag)
      else $error("power count flag rose below threshold");
   AST_SLM: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      restore_busy_i |-> ##2 information_status_word_o[BIT_START_LIM])
      else $error("start limit bit missing");
   AST_SLM_OFF: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !(teach_busy_i || config_busy_i || data_write_busy_i ||
        restore_busy_i) |-> ##2 !information_status_word_o[BIT_START_LIM])
      else $error("start limit bit stuck");
   AST_IOT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !io_test_busy_i && !config_busy_i |=> !io_test_mode_flag)
      else $error("io test flag stuck");
   AST_IOT_SET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      io_test_busy_i || config_busy_i |=> io_test_mode_flag)
      else $error("io test flag missing");
   AST_CFG: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      config_exec_i && !config_param_chg_i |=>
      !configuration_request_flag)
      else $error("configuration request not cleared");
   AST_CFG_SET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      config_param_chg_i |=> configuration_request_flag)
      else $error("configuration request not set");
   AST_RBT: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      $rose(power_cycle_request_flag) |=> power_cycle_request_flag[*8])
      else $error("power cycle request cleared");
   AST_RBT_HOLD: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      power_cycle_request_flag |=> power_cycle_request_flag)
      else $error("power cycle request dropped without power-up");
   AST_SAVE: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      nv_save_o |=> !nv_save_o)
      else $error("save strobe longer than one cycle");
   AST_NET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      comm_ok_i && !comm_err_i |=> !serial_comm_error_flag)
      else $error("comm error flag not cleared");
   AST_NET_SET: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      comm_err_i && comm_err_count_i >= comm_err_thr_i |=>
      serial_comm_error_flag)
      else $error("comm error flag not set");
   AST_ZERO: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      (information_status_word_o & ~STATUS_USED_MASK) == '0)
      else $error("unassigned bit set");
   AST_OR: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      drv_temp_cond_i && overvolt_cond_i |=>
      information_status_word_o[BIT_DRV_TEMP] &&
      information_status_word_o[BIT_OVERVOLT])
      else $error("combined code lost a bit");
   AST_ODO: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      odometer_cond_i |=> information_status_word_o[BIT_ODOMETER])
      else $error("odometer bit missing");

   COV_CFG: cover property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(configuration_request_flag));
   COV_PTIME: cover property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(power_on_time_flag));
   COV_SAVE: cover property (@(posedge core_clk_i) disable iff (reset_i)
      nv_save_o);
   COV_RBT: cover property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(power_cycle_request_flag));
   COV_NET: cover property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(serial_comm_error_flag));
endmodule : dis_status_word

/* File: tb_dis_status_word.sv */
// testbench for the information status word
`timescale 1ns/100ps
module tb_dis_status_word;
   import dis_pkg::*;
   // short save period keeps the run brief
   localparam longint unsigned SP = 20;
   logic core_clk_i = 0;
   logic reset_i = 1;
   logic [VAL_W-1:0] tl = '0, tm = '0, ss = '0, su = '0;
   logic [VAL_W-1:0] sl = '0, cc = '0, ct = '0;
   logic [CNT_W-1:0] pt = '0, ptt = 32'h0000_0010;
   logic [CNT_W-1:0] pc = '0, pct = 32'h0000_0010;
   logic [9:0] cnd = '0;
   logic [4:0] bsy = '0;
   logic [6:0] ev = '0;
   logic [STATUS_W-1:0] word, rd;
   logic nv;
   logic [31:0] r;
   int fails = 0, comparisons = 0, cyc = 0, last = -1, seed = 32'hd249;
   int lo_pos [10] = '{2, 4, 5, 7, 8, 9, 12, 19, 20, 21};
   bit m_pt, m_pc, m_cfg, m_rb, m_cm;

   always #50 core_clk_i = ~core_clk_i;

   dis_status_word #(.SAVE_PERIOD(SP)) dis_status_word_inst (
      .core_clk_i(core_clk_i), .reset_i(reset_i),
      .torque_limit_i(tl), .torque_limit_max_i(tm),
      .speed_set_i(ss), .speed_upper_i(su), .speed_lower_i(sl),
      .power_time_i(pt), .power_time_thr_i(ptt),
      .power_time_thr_wr_i(ev[0]),
      .power_count_i(pc), .power_count_thr_i(pct),
      .power_count_thr_wr_i(ev[1]),
      .teach_busy_i(bsy[0]), .config_busy_i(bsy[1]),
      .data_write_busy_i(bsy[2]), .restore_busy_i(bsy[3]),
      .io_test_busy_i(bsy[4]), .config_param_chg_i(ev[2]),
      .config_exec_i(ev[3]), .reboot_param_chg_i(ev[4]),
      .comm_err_count_i(cc), .comm_err_thr_i(ct),
      .comm_err_i(ev[5]), .comm_ok_i(ev[6]),
      .drv_temp_cond_i(cnd[0]), .overvolt_cond_i(cnd[1]),
      .undervolt_cond_i(cnd[2]), .load_cond_i(cnd[3]),
      .speed_cond_i(cnd[4]), .opdata_err_cond_i(cnd[5]),
      .op_prohib_cond_i(cnd[6]), .rot_meter_cond_i(cnd[7]),
      .tripmeter_cond_i(cnd[8]), .odometer_cond_i(cnd[9]),
      .information_status_word_o(word), .nv_save_o(nv));

   dis_host_model dis_host_model_inst (
      .core_clk_i(core_clk_i), .status_i(word), .read_word_o(rd));

   task end_of_test;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   function automatic logic [31:0] expect_word();
      logic [31:0] e;
      e = '0;
      for (int i = 0; i < 10; i++) e[lo_pos[i]] = cnd[i];
      e[15] = m_cm;
      e[24] = tl > tm;
      e[25] = ss > su || ss < sl;
      e[26] = m_pt;
      e[27] = m_pc;
      e[28] = |bsy[3:0];
      e[29] = bsy[4] | bsy[1];
      e[30] = m_cfg;
      e[31] = m_rb;
      return e;
   endfunction : expect_word

   // latency is two edges plus the host read; four leaves margin
   task automatic check_word();
      repeat (4) @(posedge core_clk_i);
      if (pt >= ptt) m_pt = 1;
      if (pc >= pct) m_pc = 1;
      chk("status", expect_word(), rd);
   endtask : check_word

   // event pulses; set is applied after clear so set wins
   task automatic pulse(logic [6:0] m);
      @(posedge core_clk_i) ev <= m;
      @(posedge core_clk_i) ev <= '0;
      if (m[3]) m_cfg = 0;
      if (m[2]) m_cfg = 1;
      if (m[4]) m_rb = 1;
      if (m[6]) m_cm = 0;
      if (m[5] && cc >= ct) m_cm = 1;
      if (m[0] && pt < ptt) m_pt = 0;
      if (m[1] && pc < pct) m_pc = 0;
      check_word();
   endtask : pulse

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
      if (reset_i) last <= -1;
      else if (nv === 1'b1) begin
         if (last >= 0) chk("save_gap", 32'(SP), 32'(cyc - last));
         last <= cyc;
      end
   end

   initial begin
      repeat (8) @(posedge core_clk_i);
      reset_i <= 0;
      check_word();
      @(posedge core_clk_i) cnd <= 10'h003;
      repeat (4) @(posedge core_clk_i);
      chk("ov_temp", 32'h0000_0014, rd);
      for (int k = 0; k < 40; k++) begin
         r = $random(seed);
         @(posedge core_clk_i) cnd <= r[9:0];
         bsy <= r[14:10];
         tl <= VAL_W'(r[17:15]);
         tm <= VAL_W'(r[20:18]);
         ss <= VAL_W'(r[23:21]);
         su <= VAL_W'(r[26:24]);
         sl <= VAL_W'(r[29:27]);
         check_word();
      end
      @(posedge core_clk_i) pt <= 32'h0000_0005;
      ptt <= 32'h0000_0005;
      pc <= 32'h0000_0007;
      pct <= 32'h0000_0007;
      check_word();
      @(posedge core_clk_i) pt <= 32'h0000_0004;
      pc <= 32'h0000_0006;
      check_word();
      @(posedge core_clk_i) ptt <= 32'h0000_0006;
      pct <= 32'h0000_0008;
      pulse(7'h03);
      pulse(7'h04);
      pulse(7'h08);
      pulse(7'h0c);
      pulse(7'h08);
      @(posedge core_clk_i) ct <= 16'h0003;
      cc <= 16'h0002;
      pulse(7'h20);
      @(posedge core_clk_i) cc <= 16'h0003;
      pulse(7'h20);
      pulse(7'h40);
      pulse(7'h10);
      // power cycle: only a reset may drop the request bit
      @(posedge core_clk_i) reset_i <= 1;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 0;
      m_rb = 0;
      m_cfg = 0;
      m_cm = 0;
      m_pt = 0;
      m_pc = 0;
      check_word();
      repeat (60) @(posedge core_clk_i);
      end_of_test();
   end
endmodule : tb_dis_status_word
